// file: logic/fspc_defines.svh
`ifndef FSPC_DEFINES_SVH
`define FSPC_DEFINES_SVH

// register word indices, index taken from haddr[4:2]
`define FSPC_IDX_CTRL    3'h0
`define FSPC_IDX_PTR     3'h1
`define FSPC_IDX_DATA    3'h2
`define FSPC_IDX_CMD     3'h3
`define FSPC_IDX_RESULT  3'h4

// control/status bit positions
`define FSPC_B_EN        0
`define FSPC_B_ERASE     1
`define FSPC_B_WRITE     2
`define FSPC_B_LOCKSET   3
`define FSPC_B_REEN      4
`define FSPC_B_BUSY      6
`define FSPC_B_IE        7

// command register bits and result valid bit
`define FSPC_B_STORE     0
`define FSPC_B_LOAD      1
`define FSPC_B_RVALID    8

// pointer fields
`define FSPC_PAGE_MSB    14
`define FSPC_PAGE_LSB    7
`define FSPC_WORD_MSB    6
`define FSPC_WORD_LSB    1
`define FSPC_HALT_PAGE   8'he0

// readout selectors on the pointer
`define FSPC_SEL_FLOW    16'h0000
`define FSPC_SEL_LOCK    16'h0001
`define FSPC_SEL_FEXT    16'h0002
`define FSPC_SEL_FHIGH   16'h0003

// reset values
`define FSPC_LOCK_RST    8'hff
`define FSPC_LOCK_KEEP   2'b11
`define FSPC_EMPTY_WORD  16'hffff

// instruction windows in cycles after the control write
`define FSPC_STORE_WIN   3'h4
`define FSPC_LOAD_LAST   3'h2

// programming time
`define FSPC_CLK_NS      10
`define FSPC_PROG_MIN_NS 3700000
`define FSPC_PROG_MAX_NS 4500000
`define FSPC_PROG_CYC    ((`FSPC_PROG_MIN_NS + `FSPC_CLK_NS - 1) / `FSPC_CLK_NS)
`define FSPC_TMR_W       19

`endif

// file: logic/fspc_pkg.sv
package fspc_pkg;
	typedef enum logic [1:0] {
		FSPC_OP_NONE,
		FSPC_OP_ERASE,
		FSPC_OP_WRITE,
		FSPC_OP_LOCK
	} fspc_op_type;

	typedef struct packed {
		logic        busy;
		logic        done;
		logic [18:0] cnt;
	} fspc_tmr_type;

	typedef struct packed {
		logic        ap_wr;
		logic        ap_hit;
		logic [2:0]  ap_idx;
		logic [31:0] rdata;
		logic        en;
		logic        erase;
		logic        write;
		logic        lockset;
		logic        reen;
		logic        ie;
		logic        busy;
		logic [2:0]  win;
		logic [15:0] ptr;
		logic [15:0] data;
		logic [7:0]  lock;
		logic [7:0]  result;
		logic        rvalid;
		logic [63:0] loaded;
		fspc_op_type op;
		logic [7:0]  op_page;
		logic        op_halt;
		logic        start;
		logic        normal_load;
		logic [15:0] buf_word;
	} fspc_state_type;
endpackage

// file: logic/fspc_timer.sv
`timescale 1ns/10ps
`include "fspc_defines.svh"

module fspc_timer
	import fspc_pkg::*;
#(
	parameter logic [`FSPC_TMR_W-1:0] CYCLES = `FSPC_TMR_W'(`FSPC_PROG_CYC)
) (
	input  wire logic hclk,
	input  wire logic hresetn,
	input  wire logic start,
	output logic      busy,
	output logic      done
);
	fspc_tmr_type s, n;

	// counts the flash programming time; a start while busy is ignored
	always_comb begin
		n = s;
		n.done = 1'b0;
		if (s.busy) begin
			if (s.cnt == `FSPC_TMR_W'(1)) begin
				n.busy = 1'b0;
				n.done = 1'b1;
			end else begin
				n.cnt = s.cnt - `FSPC_TMR_W'(1);
			end
		end else if (start) begin
			n.busy = 1'b1;
			n.cnt  = CYCLES;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign busy = s.busy;
	assign done = s.done;
endmodule

// file: logic/fspc_ctrl.sv
`timescale 1ns/10ps
`include "fspc_defines.svh"

// What this block does
// RULE1 - erase code then store within four cycles erases the pointer's page
// RULE2 - erase uses only the page field; other pointer bits and data ignored
// RULE3 - erase/write of halting section halts the CPU; otherwise halting code readable
// RULE4 - load code then store puts data word into buffer slot by word field
// RULE5 - buffer cleared after page write, on re-enable write and on reset
// RULE6 - software loads each buffer slot only once between clears
// RULE7 - an EEPROM write during page loading discards loaded buffer data
// RULE8 - write code then store programs the buffer into the pointer's page
// RULE9 - interrupt asserted while enabled and the enable bit reads cleared
// RULE10 - erase or write blocks reads of readable section; busy flag set
// RULE11 - busy stays set after completion until re-enable is written
// RULE12 - lock code then store within four cycles sets lock bits from data
// RULE13 - cleared data bits 5..0 program lock bits; pointer ignored
// RULE14 - whole flash stays readable while lock bits program
// RULE15 - EEPROM write busy blocks programming and fuse/lock reads
// RULE16 - software checks EEPROM busy clear before writing control
// RULE17 - pointer one, lock-set and enable, then load within three cycles locks
// RULE18 - lock-set and enable clear after a read or when windows lapse
// RULE19 - with those bits clear, loads behave as normal flash reads
// RULE20 - pointer zero low fuse, three high fuse, two extended fuse
// RULE21 - programmed bits read zero, unprogrammed bits read one
// RULE22 - buffer loads accepted in any order before or after an erase
// RULE23 - erase, write or lock write lasts 3.7 to 4.5 ms
// RULE24 - enable bit stays set during an operation stored before the window's last cycle and clears at its end
module fspc_ctrl
	import fspc_pkg::*;
#(
	parameter logic [`FSPC_TMR_W-1:0] PROG_CYCLES = `FSPC_TMR_W'(`FSPC_PROG_CYC)
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic        eeprom_write_busy,
	input  wire logic        eeprom_write_start,
	input  wire logic [7:0]  fuse_low_byte,
	input  wire logic [7:0]  fuse_high_byte,
	input  wire logic [7:0]  fuse_extended_byte,
	input  wire logic [5:0]  buf_rd_index,
	output logic [15:0]      buf_rd_word,
	output logic             prog_start,
	output logic [1:0]       prog_kind,
	output logic [7:0]       prog_page,
	output logic             prog_busy,
	output logic             cpu_halt,
	output logic             read_section_busy,
	output logic             normal_load,
	output logic             selfprog_irq
);
	fspc_state_type s, n;
	logic [15:0]    buf_mem [64];
	logic           tmr_done;
	logic           tmr_busy;
	logic           ap;
	logic           wr_ctrl;
	logic           wr_ptr;
	logic           wr_data;
	logic           do_store;
	logic           do_load;
	logic           armed_read;
	logic           we;
	logic [5:0]     widx;
	logic [7:0]     zpage;
	logic [5:0]     zword;

	// programming duration from the calibrated clock
	fspc_timer #(
		.CYCLES (PROG_CYCLES)
	) u_timer (
		.hclk    (hclk),
		.hresetn (hresetn),
		.start   (s.start),
		.busy    (tmr_busy),
		.done    (tmr_done)
	);

	// data phase decode of the registered address phase
	assign ap      = hsel && hready && htrans[1];
	assign wr_ctrl = s.ap_wr && s.ap_hit && (s.ap_idx == `FSPC_IDX_CTRL);
	assign wr_ptr  = s.ap_wr && s.ap_hit && (s.ap_idx == `FSPC_IDX_PTR);
	assign wr_data = s.ap_wr && s.ap_hit && (s.ap_idx == `FSPC_IDX_DATA);
	assign do_store = s.ap_wr && s.ap_hit && (s.ap_idx == `FSPC_IDX_CMD)
		&& hwdata[`FSPC_B_STORE];
	assign do_load = s.ap_wr && s.ap_hit && (s.ap_idx == `FSPC_IDX_CMD)
		&& hwdata[`FSPC_B_LOAD];
	assign armed_read = s.en && s.lockset && !s.erase && !s.write
		&& (s.win >= `FSPC_LOAD_LAST) && (s.op == FSPC_OP_NONE);
	assign zpage = s.ptr[`FSPC_PAGE_MSB:`FSPC_PAGE_LSB];
	assign zword = s.ptr[`FSPC_WORD_MSB:`FSPC_WORD_LSB];

	// next state: bus slave, command sequencer and buffer bookkeeping
	always_comb begin
		n = s;
		we = 1'b0;
		widx = zword;
		n.start = 1'b0;
		n.normal_load = 1'b0;
		n.ap_wr = ap && hwrite;
		n.ap_idx = haddr[4:2];
		n.ap_hit = (haddr[31:5] == 27'h0) && (haddr[4:2] <= `FSPC_IDX_RESULT);
		n.rdata = 32'h0;
		if (ap && !hwrite) begin
			unique case (haddr[4:2])
				`FSPC_IDX_CTRL: n.rdata = {24'h0, s.ie, s.busy, 1'b0, s.reen,
					s.lockset, s.write, s.erase, s.en};
				`FSPC_IDX_PTR: n.rdata = {16'h0, s.ptr};
				`FSPC_IDX_DATA: n.rdata = {16'h0, s.data};
				`FSPC_IDX_RESULT: n.rdata = {23'h0, s.rvalid, s.result};
				default: n.rdata = 32'h0;
			endcase
			if (haddr[31:5] != 27'h0) begin
				n.rdata = 32'h0;
			end
		end
		if (wr_ptr) begin
			n.ptr = hwdata[15:0];
		end
		if (wr_data) begin
			n.data = hwdata[15:0];
		end
		// the window counts down once armed
		if (s.win != 3'h0) begin
			n.win = s.win - 3'h1;
		end
		// lapsed window drops the command bits, running ops keep theirs
		if (s.win == 3'h1 && s.op == FSPC_OP_NONE) begin
			n.en = 1'b0; // RULE18
			n.erase = 1'b0;
			n.write = 1'b0;
			n.lockset = 1'b0;
			n.reen = 1'b0;
		end
		// eeprom busy refuses new commands; during an op only the ie bit takes a control write
		if (wr_ctrl) begin
			n.ie = hwdata[`FSPC_B_IE];
			if (!eeprom_write_busy && s.op == FSPC_OP_NONE) begin // RULE15
				n.en = hwdata[`FSPC_B_EN];
				n.erase = hwdata[`FSPC_B_ERASE];
				n.write = hwdata[`FSPC_B_WRITE];
				n.lockset = hwdata[`FSPC_B_LOCKSET];
				n.reen = hwdata[`FSPC_B_REEN];
				n.win = hwdata[`FSPC_B_EN] ? `FSPC_STORE_WIN : 3'h0;
			end
		end
		if (do_store && s.en && s.win != 3'h0 && s.op == FSPC_OP_NONE) begin
			n.win = 3'h0;
			if (s.erase && !s.write && !s.lockset) begin
				n.op = FSPC_OP_ERASE; // RULE1
				n.op_page = zpage; // RULE2
				n.op_halt = zpage >= `FSPC_HALT_PAGE; // RULE3
				n.busy = 1'b1; // RULE10
				n.start = 1'b1;
			end else if (s.write && !s.erase && !s.lockset) begin
				n.op = FSPC_OP_WRITE; // RULE8
				n.op_page = zpage;
				n.op_halt = zpage >= `FSPC_HALT_PAGE;
				n.busy = 1'b1;
				n.start = 1'b1;
			end else if (s.lockset && !s.erase && !s.write) begin
				n.op = FSPC_OP_LOCK; // RULE12
				n.op_page = s.data[7:0]; // RULE13
				n.op_halt = 1'b0; // RULE14
				n.start = 1'b1;
			end else if (s.reen && !s.erase && !s.write) begin
				n.busy = 1'b0; // RULE11
				n.loaded = 64'h0; // RULE5
				n.en = 1'b0;
				n.reen = 1'b0;
			end else if (!s.erase && !s.write && !s.reen) begin
				// a second load into a filled slot is dropped
				if (!s.loaded[zword]) begin // RULE6
					we = 1'b1; // RULE4 RULE22
					n.loaded[zword] = 1'b1;
				end
				n.en = 1'b0;
			end else begin
				n.en = 1'b0;
				n.erase = 1'b0;
				n.write = 1'b0;
				n.lockset = 1'b0;
				n.reen = 1'b0;
			end
		end
		// fuse and lock readout; unmatched pointers read all ones
		if (do_load) begin
			if (armed_read) begin
				n.en = 1'b0; // RULE18
				n.lockset = 1'b0;
				n.win = 3'h0;
				if (!eeprom_write_busy) begin // RULE15
					n.rvalid = 1'b1;
					unique case (s.ptr)
						`FSPC_SEL_FLOW: n.result = fuse_low_byte; // RULE20 RULE21
						`FSPC_SEL_LOCK: n.result = s.lock; // RULE17
						`FSPC_SEL_FEXT: n.result = fuse_extended_byte;
						`FSPC_SEL_FHIGH: n.result = fuse_high_byte;
						default: n.result = 8'hff;
					endcase
				end
			end else if (!(s.en && s.lockset)) begin
				n.normal_load = 1'b1; // RULE19
			end
		end
		// end of a timed operation
		if (tmr_done && s.op != FSPC_OP_NONE) begin
			if (s.op == FSPC_OP_LOCK) begin
				n.lock = s.lock & {`FSPC_LOCK_KEEP, s.op_page[5:0]}; // RULE13
			end
			if (s.op == FSPC_OP_WRITE) begin
				n.loaded = 64'h0; // RULE5
			end
			n.op = FSPC_OP_NONE;
			n.op_halt = 1'b0;
			n.en = 1'b0; // RULE24
			n.erase = 1'b0;
			n.write = 1'b0;
			n.lockset = 1'b0;
		end
		// an eeprom write wipes whatever was loaded so far
		if (eeprom_write_start) begin
			n.loaded = 64'h0; // RULE7
			we = 1'b0;
		end
		n.buf_word = s.loaded[buf_rd_index] ? buf_mem[buf_rd_index]
			: `FSPC_EMPTY_WORD;
	end

	// state register; the loaded mask clearing empties the buffer on reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s <= '0;
			s.lock <= `FSPC_LOCK_RST;
			s.result <= 8'hff;
			s.buf_word <= `FSPC_EMPTY_WORD; // RULE5
		end else begin
			s <= n;
		end
	end

	// buffer words carry no reset: the mask decides what is valid
	always_ff @(posedge hclk) begin
		if (we) begin
			buf_mem[widx] <= s.data;
		end
	end

	assign hreadyout         = 1'b1;
	assign hresp             = 1'b0;
	assign hrdata            = s.rdata;
	assign buf_rd_word       = s.buf_word;
	assign prog_start        = s.start;
	assign prog_kind         = s.op;
	assign prog_page         = s.op_page;
	assign prog_busy         = tmr_busy; // RULE23
	assign cpu_halt          = s.op_halt; // RULE3
	assign read_section_busy = s.busy; // RULE10
	assign normal_load       = s.normal_load;
	// level interrupt: stays high while ie is set and enable reads clear
	assign selfprog_irq      = s.ie && !s.en; // RULE9

	sequence s_armed;
		wr_ctrl && !eeprom_write_busy && s.op == FSPC_OP_NONE
			&& hwdata[`FSPC_B_EN];
	endsequence

	sequence s_no_cmd4;
		(!do_store && !do_load && !wr_ctrl && !tmr_done) [*4];
	endsequence

	property p_erase_start;
		@(posedge hclk) disable iff (!hresetn)
		do_store && s.en && s.erase && !s.write && !s.lockset && s.win != 3'h0
			&& s.op == FSPC_OP_NONE
		|=> prog_start && prog_kind == 2'(FSPC_OP_ERASE)
			&& prog_page == $past(zpage) && read_section_busy;
	endproperty
	a_erase_start: assert property (p_erase_start) else $error("erase not started"); // RULE1

	property p_halt;
		@(posedge hclk) disable iff (!hresetn)
		cpu_halt |-> prog_page >= `FSPC_HALT_PAGE && prog_kind != 2'(FSPC_OP_LOCK);
	endproperty
	a_halt: assert property (p_halt) else $error("halt on wrong target"); // RULE3

	property p_load_slot;
		@(posedge hclk) disable iff (!hresetn)
		we && !eeprom_write_start |=> s.loaded[$past(widx)] && !s.en;
	endproperty
	a_load_slot: assert property (p_load_slot) else $error("buffer slot not marked"); // RULE4

	property p_write_clears;
		@(posedge hclk) disable iff (!hresetn)
		tmr_done && s.op == FSPC_OP_WRITE |=> s.loaded == 64'h0 && !s.en;
	endproperty
	a_write_clears: assert property (p_write_clears) else $error("buffer kept"); // RULE5

	property p_ee_discard;
		@(posedge hclk) disable iff (!hresetn)
		eeprom_write_start |=> s.loaded == 64'h0;
	endproperty
	a_ee_discard: assert property (p_ee_discard) else $error("loads survived eeprom"); // RULE7

	property p_irq;
		@(posedge hclk) disable iff (!hresetn)
		s.ie && $fell(s.en) |-> selfprog_irq ##1 (selfprog_irq || s.en || !s.ie);
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt missing"); // RULE9

	property p_busy_hold;
		@(posedge hclk) disable iff (!hresetn)
		read_section_busy && !(do_store && s.reen) |=> read_section_busy;
	endproperty
	a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early"); // RULE11

	property p_window;
		@(posedge hclk) disable iff (!hresetn)
		s_armed ##1 s_no_cmd4 |=> !s.en && !s.lockset;
	endproperty
	a_window: assert property (p_window) else $error("window did not lapse"); // RULE18

	property p_ee_block;
		@(posedge hclk) disable iff (!hresetn)
		wr_ctrl && eeprom_write_busy && !tmr_done && !do_load && s.win == 3'h0
		|=> s.en == $past(s.en) && s.erase == $past(s.erase);
	endproperty
	a_ee_block: assert property (p_ee_block) else $error("control taken in eeprom"); // RULE15

	property p_fuse_low;
		@(posedge hclk) disable iff (!hresetn)
		do_load && armed_read && !eeprom_write_busy && s.ptr == `FSPC_SEL_FLOW
		|=> s.result == $past(fuse_low_byte) && s.rvalid && !s.en;
	endproperty
	a_fuse_low: assert property (p_fuse_low) else $error("wrong fuse byte"); // RULE20
endmodule

// file: tb/fspc_far_model.sv
`timescale 1ns/10ps
// far side of the block: eeprom engine, fuse bank and the buffer read index
module fspc_far_model #(
	parameter logic [7:0] FUSE_LO = 8'h62,
	parameter logic [7:0] FUSE_HI = 8'h99,
	parameter logic [7:0] FUSE_EX = 8'hfd
) (
	input  wire logic       hclk,
	input  wire logic       hresetn,
	input  wire logic       ee_req,
	input  wire logic [5:0] rd_index,
	output logic            eeprom_write_busy,
	output logic            eeprom_write_start,
	output logic [7:0]      fuse_low_byte,
	output logic [7:0]      fuse_high_byte,
	output logic [7:0]      fuse_extended_byte,
	output logic [5:0]      buf_rd_index
);
	logic [4:0] ee_cnt_r;

	// fuse bits are fixed; a cleared bit means programmed
	assign fuse_low_byte      = FUSE_LO;
	assign fuse_high_byte     = FUSE_HI;
	assign fuse_extended_byte = FUSE_EX;
	assign buf_rd_index       = rd_index;
	assign eeprom_write_busy  = ee_cnt_r != 5'h00;

	// an eeprom write runs a fixed span; a request while busy is dropped
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ee_cnt_r           <= 5'h00;
			eeprom_write_start <= 1'b0;
		end else begin
			eeprom_write_start <= ee_req && ee_cnt_r == 5'h00;
			if (ee_req && ee_cnt_r == 5'h00) begin
				ee_cnt_r <= 5'h14;
			end else if (ee_cnt_r != 5'h00) begin
				ee_cnt_r <= ee_cnt_r - 5'h01;
			end
		end
	end
endmodule

// file: tb/flash_self_programming_ctrl_test.sv
`timescale 1ns/10ps
module flash_self_programming_ctrl_test;
	import fspc_pkg::*;
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic        hreadyout;
	logic        hresp;
	logic [31:0] hrdata;
	logic        ee_busy, ee_start, ee_req;
	logic [7:0]  f_lo, f_hi, f_ex;
	logic [5:0]  rd_index, buf_idx;
	logic [15:0] buf_rd_word;
	logic        prog_start, prog_busy, cpu_halt, read_section_busy, normal_load, selfprog_irq;
	logic [1:0]  prog_kind, last_kind;
	logic [7:0]  prog_page, last_page;
	logic [7:0]  fuse_exp [4] = '{8'h62, 8'hff, 8'hfd, 8'h99};
	int          mismatches, cmp_count, busy_cycles, loads;

	fspc_ctrl #(.PROG_CYCLES(19'h14)) u_dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.eeprom_write_busy(ee_busy), .eeprom_write_start(ee_start),
		.fuse_low_byte(f_lo), .fuse_high_byte(f_hi), .fuse_extended_byte(f_ex),
		.buf_rd_index(buf_idx), .buf_rd_word(buf_rd_word), .prog_start(prog_start),
		.prog_kind(prog_kind), .prog_page(prog_page), .prog_busy(prog_busy),
		.cpu_halt(cpu_halt), .read_section_busy(read_section_busy), .normal_load(normal_load),
		.selfprog_irq(selfprog_irq)
	);

	fspc_far_model u_far (
		.hclk(hclk), .hresetn(hresetn), .ee_req(ee_req), .rd_index(rd_index),
		.eeprom_write_busy(ee_busy), .eeprom_write_start(ee_start),
		.fuse_low_byte(f_lo), .fuse_high_byte(f_hi), .fuse_extended_byte(f_ex),
		.buf_rd_index(buf_idx)
	);

	// free-running 100 MHz clock
	always #5 hclk = ~hclk;

	// watch the one-cycle pulses and the timer length at every edge
	always @(posedge hclk) begin
		if (prog_busy === 1'b1) busy_cycles++;
		if (normal_load === 1'b1) loads++;
		if (prog_start === 1'b1) begin
			last_kind = prog_kind;
			last_page = prog_page;
		end
	end

	task automatic report_and_stop;
		$display("mismatches %0d comparisons %0d", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one single transfer; the master never assumes a wait count
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		htrans <= 2'b10;
		haddr  <= a;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] v;
		bus(1'b1, a, d, v);
	endtask

	task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
		logic [31:0] v;
		bus(1'b0, a, 32'h0, v);
		check(v, exp);
	endtask

	// control write then the instruction strobe two cycles later, inside the window
	task automatic cmd(input logic [31:0] ctrl, input logic [31:0] c);
		wr(32'h00, ctrl);
		wr(32'h0c, c);
	endtask

	task automatic load_word(input logic [5:0] slot, input logic [15:0] d);
		wr(32'h04, {25'h0, slot, 1'b0});
		wr(32'h08, {16'h0, d});
		cmd(32'h01, 32'h01);
	endtask

	task automatic buf_chk(input logic [5:0] slot, input logic [15:0] exp);
		rd_index <= slot;
		repeat (2) @(posedge hclk);
		check({16'h0, buf_rd_word}, {16'h0, exp});
	endtask

	// polls the enable bit, bounded so a stuck operation cannot hang the run
	task automatic wait_idle;
		logic [31:0] v;
		v = 32'h1;
		for (int k = 0; k < 50 && v[0] !== 1'b0; k++) bus(1'b0, 32'h00, 32'h0, v);
		// a poll that runs out counts as a mismatch
		check(v[0], 1'b0);
	endtask

	// hang guard: the sequence needs well under 2000 cycles
	initial begin
		#200000;
		mismatches++;
		report_and_stop();
	end

	initial begin
		hclk = 1'b0; hresetn = 1'b0; hsel = 1'b1; haddr = 32'h0; htrans = 2'b00;
		hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0; ee_req = 1'b0; rd_index = 6'h00;
		mismatches = 0; cmp_count = 0; busy_cycles = 0; loads = 0;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd_chk(32'h00, 32'h0);
		rd_chk(32'h10, 32'h0ff);
		rd_chk(32'h20, 32'h0);
		buf_chk(6'h05, 16'hffff);
		// every readout selector, with the bits clearing after each read
		for (int i = 0; i < 4; i++) begin
			wr(32'h04, i);
			cmd(32'h09, 32'h02);
			rd_chk(32'h10, {23'h0, 1'b1, fuse_exp[i]});
			rd_chk(32'h00, 32'h0);
		end
		// lapsed window leaves a plain flash load
		wr(32'h00, 32'h09);
		repeat (6) @(posedge hclk);
		rd_chk(32'h00, 32'h0);
		busy_cycles = loads;
		wr(32'h0c, 32'h02);
		repeat (2) @(posedge hclk);
		check(loads, busy_cycles + 1);
		// out-of-order loads and a refused second load into a slot
		load_word(6'h05, 16'h1234);
		load_word(6'h02, 16'h0abc);
		load_word(6'h05, 16'hbeef);
		buf_chk(6'h05, 16'h1234);
		buf_chk(6'h02, 16'h0abc);
		// an eeprom write drops the buffer and locks out the control bits
		ee_req <= 1'b1;
		@(posedge hclk);
		ee_req <= 1'b0;
		@(posedge hclk); // the discard lands one cycle after the start pulse
		buf_chk(6'h05, 16'hffff);
		wr(32'h00, 32'h89);
		rd_chk(32'h00, 32'h80);
		check({hreadyout, hresp}, 2'b10);
		check(selfprog_irq, 1'b1);
		for (int k = 0; k < 40 && ee_busy !== 1'b0; k++) @(posedge hclk);
		check(ee_busy, 1'b0);
		wr(32'h00, 32'h00);
		@(posedge hclk); // the control write settles at the edge that ends the task
		check(selfprog_irq, 1'b0);
		// erase with junk in the word bits, buffer filled beforehand
		load_word(6'h03, 16'h5a5a);
		wr(32'h04, 32'h087f);
		busy_cycles = 0;
		cmd(32'h03, 32'h01);
		repeat (2) @(posedge hclk);
		check(last_kind, 2'h1);
		check(last_page, 8'h10);
		check(read_section_busy, 1'b1);
		check(cpu_halt, 1'b0);
		rd_chk(32'h00, 32'h43);
		wait_idle();
		check(busy_cycles, 20);
		rd_chk(32'h00, 32'h40);
		buf_chk(6'h03, 16'h5a5a);
		// page write into the halting section
		wr(32'h04, 32'h7000);
		cmd(32'h05, 32'h01);
		repeat (2) @(posedge hclk);
		check(last_kind, 2'h2);
		check(last_page, 8'he0);
		check(cpu_halt, 1'b1);
		wait_idle();
		buf_chk(6'h03, 16'hffff);
		rd_chk(32'h00, 32'h40);
		load_word(6'h04, 16'h7777);
		cmd(32'h11, 32'h01);
		rd_chk(32'h00, 32'h0);
		check(read_section_busy, 1'b0);
		buf_chk(6'h04, 16'hffff);
		// lock set with a junk pointer and the interrupt on, then read the lock byte back
		wr(32'h08, 32'h00f5);
		wr(32'h04, 32'h1234);
		cmd(32'h89, 32'h01);
		repeat (2) @(posedge hclk);
		check(last_kind, 2'h3);
		check({read_section_busy, cpu_halt, selfprog_irq}, 3'b000);
		wait_idle();
		check(selfprog_irq, 1'b1);
		wr(32'h04, 32'h01);
		cmd(32'h09, 32'h02);
		rd_chk(32'h10, 32'h1f5);
		report_and_stop();
	end
endmodule
